// ---- rtl/tmr_pkg.sv ----
// Package for the 16-bit PWM timer: register offsets, field layouts,
// reset values and the power state encoding.
// Assumes a 32-bit APB slave; each 8-bit register occupies one aligned word.
package tmr_pkg;

  // ===========================================================
  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL2 = 8'h00;
  localparam logic [7:0] ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] ADDR_CSR = 8'h08;
  localparam logic [7:0] ADDR_CAP1_HI = 8'h0c;
  localparam logic [7:0] ADDR_CAP1_LO = 8'h10;
  localparam logic [7:0] ADDR_CMP1_HI = 8'h14;
  localparam logic [7:0] ADDR_CMP1_LO = 8'h18;
  localparam logic [7:0] ADDR_CNT_HI = 8'h1c;
  localparam logic [7:0] ADDR_CNT_LO = 8'h20;
  localparam logic [7:0] ADDR_ACNT_HI = 8'h24;
  localparam logic [7:0] ADDR_ACNT_LO = 8'h28;
  localparam logic [7:0] ADDR_CAP2_HI = 8'h2c;
  localparam logic [7:0] ADDR_CAP2_LO = 8'h30;
  localparam logic [7:0] ADDR_CMP2_HI = 8'h34;
  localparam logic [7:0] ADDR_CMP2_LO = 8'h38;
  localparam logic [7:0] ADDR_SYSCTL = 8'h3c;

  // ===========================================================
  // Field positions.
  localparam int CSR_FLAG_LSB = 3;
  localparam int CSR_TIMD_BIT = 2;
  localparam int SYS_MASK_BIT = 0;
  localparam int SYS_HALT_BIT = 1;

  // ===========================================================
  // Reset values and counter constants.
  localparam logic [15:0] CMP_RESET = 16'h8000;
  localparam logic [15:0] CNT_RESET = 16'hfffc;
  localparam logic [15:0] CNT_RELOAD = 16'hfffc;
  localparam logic [15:0] CNT_TOP = 16'hffff;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic MASK_RESET = 1'b1;

  // ===========================================================
  // Clock select codes.
  localparam logic [1:0] CLK_DIV4 = 2'b00;
  localparam logic [1:0] CLK_DIV2 = 2'b01;
  localparam logic [1:0] CLK_DIV8 = 2'b10;
  localparam logic [1:0] CLK_EXT = 2'b11;
  localparam logic [2:0] PRESC_DIV2_END = 3'h1;
  localparam logic [2:0] PRESC_DIV4_END = 3'h3;
  localparam logic [2:0] PRESC_DIV8_END = 3'h7;

  typedef struct packed {
    logic capture_irq_enable;
    logic compare_irq_enable;
    logic overflow_irq_enable;
    logic force_level_two;
    logic force_level_one;
    logic second_match_level;
    logic capture_one_edge;
    logic first_match_level;
  } ctrl1_t;

  typedef struct packed {
    logic compare_pin_route_enable;
    logic compare_two_pin_enable;
    logic single_pulse_enable;
    logic pwm_enable;
    logic [1:0] timer_clock_select;
    logic capture_two_edge;
    logic ext_clock_edge;
  } ctrl2_t;

  // Flag vector order: capture one, compare one, overflow, capture two, compare two.
  typedef struct packed {
    logic capture_one_flag;
    logic compare_one_flag;
    logic overflow_flag;
    logic capture_two_flag;
    logic compare_two_flag;
  } flags_t;

  typedef enum logic [1:0] {
    PWR_RUN = 2'b01,
    PWR_HALT = 2'b10
  } pwr_state_t;

endpackage : tmr_pkg

// ---- rtl/timer16_pwm.sv ----
// 16-bit timer with output compare, input capture, PWM mode and HALT support.
// Assumes all inputs synchronous to CLK_I and an APB master on the register port.
//
// Notes on behaviour
// - PWM period match reloads the counter with FFFCh.
// - PWM pulse match drives the first level bit onto the pin.
// - PWM period match drives the second level bit onto the pin.
// - First level one, second zero gives high pulse of period minus pulse.
// - Equal level bits keep the pin constant.
// - Each interval lasts compare value plus five ticks.
// - Writing a compare high byte inhibits it until its low byte is written.
// - PWM mode never sets either compare flag.
// - PWM period match sets capture one flag, may interrupt.
// - PWM disconnects capture pin one; capture pin two still works.
// - PWM enable wins over single pulse enable.
// - Flash variant: second compare register write only, reads return zero.
// - Flash variant: no second capture registers, its flag held zero.
// - WAIT leaves the timer running; enabled interrupts wake from WAIT.
// - HALT freezes registers and counter; interrupt wake resumes the count.
// - Capture edge during HALT arms; interrupt wake sets flag, captures count.
// - Flags gated by their enables; wake WAIT, never HALT.
// - All events share one interrupt, gated by enable and CPU mask.
// - Four control/status registers and six 16-bit data pairs.
// - Software configures PWM; device routes compare signal to pin.
// - Compare registers double buffered in PWM, applied at period end.
// - Clock select: 00 div4, 01 div2, 10 div8, 11 external.
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module timer16_pwm
  import tmr_pkg::*;
#(
  parameter bit FLASH_VARIANT = 1'b0
) (
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic EXT_CLK_I,
  input wire logic CAPTURE_PIN_ONE_I,
  input wire logic CAPTURE_PIN_TWO_I,
  input wire logic HALT_WAKE_I,
  output logic COMPARE_OUTPUT_PIN_O,
  output logic COMPARE_OUTPUT_OE_O,
  output logic IRQ_O,
  output logic WAIT_WAKE_O
);

  // ===========================================================
  // Register state.
  ctrl1_t ctrl1_q;
  ctrl2_t ctrl2_q;
  flags_t flags_q, flags_d, arm_q, set_evt, clr_evt;
  pwr_state_t pwr_q;
  logic [15:0] cnt_q, acnt_q, cmp1_q, cmp2_q, cmp1_act_q, cmp2_act_q, cap1_q, cap2_q;
  logic [2:0] presc_q;
  logic [1:0] halt_arm_q;
  logic [31:0] prdata_q;
  logic timer_off_q, cpu_mask_q, cmp1_inh_q, cmp2_inh_q;
  logic ext_prev_q, cap1_prev_q, cap2_prev_q;
  logic pin_q, oe_q, irq_q, wake_q, pready_q, pslverr_q;
  logic [7:0] wbyte;
  logic acc_done, wr_done, rd_done, pwm_mode, running, sel_tick, tick, halt_exit, halted;
  logic period_hit, pulse_hit, cmp1_hit, cmp2_hit, overflow_hit, cap1_evt, cap2_evt, irq_req;

  // ===========================================================
  // Bus decode helpers.
  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a <= ADDR_SYSCTL) && (a[1:0] == 2'b00);
  endfunction : addr_known

  function automatic logic edge_seen(input logic now, input logic prev, input logic rising);
    edge_seen = rising ? (now & ~prev) : (~now & prev);
  endfunction : edge_seen

  // A transfer completes at the edge where the registered ready is seen high.
  assign acc_done = PSEL_I & PENABLE_I & pready_q;
  assign wr_done = acc_done & PWRITE_I & addr_known(PADDR_I);
  assign rd_done = acc_done & ~PWRITE_I & addr_known(PADDR_I);
  assign wbyte = PWDATA_I[7:0];

  // PWM overrides single pulse mode entirely when both are set.
  assign pwm_mode = ctrl2_q.pwm_enable;
  assign halted = (pwr_q == PWR_HALT);
  assign halt_exit = halted & HALT_WAKE_I;

  // ===========================================================
  // Tick generation from the prescaler or the external clock pin.
  always_comb begin
    case (ctrl2_q.timer_clock_select)
      CLK_DIV4: sel_tick = (presc_q[1:0] == PRESC_DIV4_END[1:0]);
      CLK_DIV2: sel_tick = (presc_q[0] == PRESC_DIV2_END[0]);
      CLK_DIV8: sel_tick = (presc_q == PRESC_DIV8_END);
      default: sel_tick = edge_seen(EXT_CLK_I, ext_prev_q, ctrl2_q.ext_clock_edge);
    endcase
  end

  // Timer disable and HALT both freeze the count; WAIT has no effect at all.
  assign running = ~halted & ~timer_off_q;
  assign tick = running & sel_tick;

  // Matching at the tick and reloading on it stretches every interval by five ticks.
  assign period_hit = tick & pwm_mode & ~cmp2_inh_q & (cnt_q == cmp2_act_q);
  assign pulse_hit = tick & pwm_mode & ~cmp1_inh_q & (cnt_q == cmp1_act_q);
  assign cmp1_hit = tick & ~pwm_mode & ~cmp1_inh_q & (cnt_q == cmp1_q);
  assign cmp2_hit = tick & ~pwm_mode & ~cmp2_inh_q & (cnt_q == cmp2_q);
  assign overflow_hit = tick & ~period_hit & (cnt_q == CNT_TOP);

  // Capture one is disconnected in PWM mode; capture two stays live.
  assign cap1_evt = ~halted & ~pwm_mode
    & edge_seen(CAPTURE_PIN_ONE_I, cap1_prev_q, ctrl1_q.capture_one_edge);
  assign cap2_evt = ~halted & ~FLASH_VARIANT
    & edge_seen(CAPTURE_PIN_TWO_I, cap2_prev_q, ctrl2_q.capture_two_edge);

  // ===========================================================
  // Prescaler and edge history.
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      presc_q <= 3'h0;
      ext_prev_q <= 1'b0;
      cap1_prev_q <= 1'b0;
      cap2_prev_q <= 1'b0;
    end else begin
      if (running) begin
        presc_q <= presc_q + 3'h1;
      end
      ext_prev_q <= EXT_CLK_I;
      cap1_prev_q <= CAPTURE_PIN_ONE_I;
      cap2_prev_q <= CAPTURE_PIN_TWO_I;
    end
  end

  // ===========================================================
  // Free-running counter and its alternate copy.
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      cnt_q <= CNT_RESET;
      acnt_q <= CNT_RESET;
    end else if (period_hit) begin
      cnt_q <= CNT_RELOAD;
      acnt_q <= CNT_RELOAD;
    end else if (tick) begin
      cnt_q <= cnt_q + 16'h0001;
      acnt_q <= acnt_q + 16'h0001;
    end
  end

  // ===========================================================
  // Compare registers, high-byte inhibit and PWM double buffering.
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      cmp1_q <= CMP_RESET;
      cmp2_q <= CMP_RESET;
      cmp1_inh_q <= 1'b0;
      cmp2_inh_q <= 1'b0;
    end else if (wr_done) begin
      case (PADDR_I)
        ADDR_CMP1_HI: {cmp1_q[15:8], cmp1_inh_q} <= {wbyte, 1'b1};
        ADDR_CMP1_LO: {cmp1_q[7:0], cmp1_inh_q} <= {wbyte, 1'b0};
        ADDR_CMP2_HI: {cmp2_q[15:8], cmp2_inh_q} <= {wbyte, 1'b1};
        ADDR_CMP2_LO: {cmp2_q[7:0], cmp2_inh_q} <= {wbyte, 1'b0};
        default: begin
        end
      endcase
    end
  end

  // Active copies follow freely outside PWM; in PWM only at the period end, so a
  // half-updated value never shortens the running period.
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      cmp1_act_q <= CMP_RESET;
      cmp2_act_q <= CMP_RESET;
    end else if (!pwm_mode || period_hit) begin
      cmp1_act_q <= cmp1_q;
      cmp2_act_q <= cmp2_q;
    end
  end

  // ===========================================================
  // Capture registers, including captures armed during HALT.
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      cap1_q <= 16'h0000;
      cap2_q <= 16'h0000;
      halt_arm_q <= 2'b00;
    end else begin
      if (halted && !halt_exit) begin
        if (edge_seen(CAPTURE_PIN_ONE_I, cap1_prev_q, ctrl1_q.capture_one_edge) && !pwm_mode) begin
          halt_arm_q[0] <= 1'b1;
        end
        if (edge_seen(CAPTURE_PIN_TWO_I, cap2_prev_q, ctrl2_q.capture_two_edge)) begin
          halt_arm_q[1] <= ~FLASH_VARIANT;
        end
      end else if (halt_exit) begin
        halt_arm_q <= 2'b00;
      end
      if (cap1_evt || (halt_exit && halt_arm_q[0])) begin
        cap1_q <= cnt_q;
      end
      if (cap2_evt || (halt_exit && halt_arm_q[1])) begin
        cap2_q <= cnt_q;
      end
    end
  end

  // ===========================================================
  // Status flags: a CSR read with the flag set arms its clear, then an access to
  // the matching low byte clears it. A new event in the clearing cycle wins.
  always_comb begin
    set_evt.capture_one_flag = cap1_evt | period_hit | (halt_exit & halt_arm_q[0]);
    set_evt.compare_one_flag = cmp1_hit;
    set_evt.overflow_flag = overflow_hit;
    set_evt.capture_two_flag = cap2_evt | (halt_exit & halt_arm_q[1]);
    set_evt.compare_two_flag = cmp2_hit & ~FLASH_VARIANT;
    clr_evt.capture_one_flag = acc_done & (PADDR_I == ADDR_CAP1_LO) & arm_q.capture_one_flag;
    clr_evt.compare_one_flag = acc_done & (PADDR_I == ADDR_CMP1_LO) & arm_q.compare_one_flag;
    clr_evt.overflow_flag = acc_done & (PADDR_I == ADDR_CNT_LO) & arm_q.overflow_flag;
    clr_evt.capture_two_flag = acc_done & (PADDR_I == ADDR_CAP2_LO) & arm_q.capture_two_flag;
    clr_evt.compare_two_flag = acc_done & (PADDR_I == ADDR_CMP2_LO) & arm_q.compare_two_flag;
    flags_d = set_evt | (flags_q & ~clr_evt);
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      flags_q <= '0;
      arm_q <= '0;
    end else begin
      flags_q <= flags_d;
      if (rd_done && (PADDR_I == ADDR_CSR)) begin
        arm_q <= (arm_q | flags_q) & ~clr_evt;
      end else begin
        arm_q <= arm_q & ~clr_evt;
      end
    end
  end

  // ===========================================================
  // Control registers, system bits and the power state.
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ctrl1_q <= ctrl1_t'(CTRL_RESET);
      ctrl2_q <= ctrl2_t'(CTRL_RESET);
      timer_off_q <= 1'b0;
      cpu_mask_q <= MASK_RESET;
    end else if (wr_done) begin
      case (PADDR_I)
        ADDR_CTRL1: ctrl1_q <= ctrl1_t'(wbyte);
        ADDR_CTRL2: ctrl2_q <= ctrl2_t'(wbyte);
        ADDR_CSR: timer_off_q <= wbyte[CSR_TIMD_BIT];
        ADDR_SYSCTL: cpu_mask_q <= wbyte[SYS_MASK_BIT];
        default: begin
        end
      endcase
    end
  end

  // HALT is entered by software and left only by an external wake; timer
  // events never leave HALT. A reset wake restarts from the reset values.
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pwr_q <= PWR_RUN;
    end else begin
      case (pwr_q)
        PWR_RUN: begin
          if (wr_done && (PADDR_I == ADDR_SYSCTL) && wbyte[SYS_HALT_BIT]) begin
            pwr_q <= PWR_HALT;
          end
        end
        PWR_HALT: begin
          if (HALT_WAKE_I) begin
            pwr_q <= PWR_RUN;
          end
        end
        default: pwr_q <= PWR_RUN;
      endcase
    end
  end

  // ===========================================================
  // Compare output pin; the latch is forced low at reset.
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pin_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      if (pwm_mode) begin
        if (period_hit) begin
          pin_q <= ctrl1_q.second_match_level;
        end else if (pulse_hit) begin
          pin_q <= ctrl1_q.first_match_level;
        end
      end else if (cmp1_hit || ctrl1_q.force_level_one) begin
        pin_q <= ctrl1_q.first_match_level;
      end
      oe_q <= ctrl2_q.compare_pin_route_enable & ~timer_off_q;
    end
  end

  // ===========================================================
  // Shared interrupt and WAIT wake-up.
  assign irq_req = |(flags_q & {ctrl1_q.capture_irq_enable, ctrl1_q.compare_irq_enable,
    ctrl1_q.overflow_irq_enable, ctrl1_q.capture_irq_enable, ctrl1_q.compare_irq_enable});

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      irq_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      irq_q <= irq_req & ~cpu_mask_q;
      wake_q <= irq_req & ~halted;
    end
  end

  // ===========================================================
  // APB slave: one wait state, registered read data and error.
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= PSEL_I & PENABLE_I & ~pready_q;
      pslverr_q <= PSEL_I & PENABLE_I & ~pready_q & ~addr_known(PADDR_I);
      prdata_q <= 32'h0000_0000;
      if (PSEL_I && PENABLE_I && !pready_q && !PWRITE_I) begin
        case (PADDR_I)
          ADDR_CTRL1: prdata_q[7:0] <= ctrl1_q;
          ADDR_CTRL2: prdata_q[7:0] <= ctrl2_q;
          ADDR_CSR: prdata_q[7:0] <= {flags_q, timer_off_q, 2'b00};
          ADDR_CAP1_HI: prdata_q[7:0] <= cap1_q[15:8];
          ADDR_CAP1_LO: prdata_q[7:0] <= cap1_q[7:0];
          ADDR_CMP1_HI: prdata_q[7:0] <= cmp1_q[15:8];
          ADDR_CMP1_LO: prdata_q[7:0] <= cmp1_q[7:0];
          ADDR_CNT_HI: prdata_q[7:0] <= cnt_q[15:8];
          ADDR_CNT_LO: prdata_q[7:0] <= cnt_q[7:0];
          ADDR_ACNT_HI: prdata_q[7:0] <= acnt_q[15:8];
          ADDR_ACNT_LO: prdata_q[7:0] <= acnt_q[7:0];
          ADDR_CAP2_HI: prdata_q[7:0] <= FLASH_VARIANT ? 8'h00 : cap2_q[15:8];
          ADDR_CAP2_LO: prdata_q[7:0] <= FLASH_VARIANT ? 8'h00 : cap2_q[7:0];
          ADDR_CMP2_HI: prdata_q[7:0] <= FLASH_VARIANT ? 8'h00 : cmp2_q[15:8];
          ADDR_CMP2_LO: prdata_q[7:0] <= FLASH_VARIANT ? 8'h00 : cmp2_q[7:0];
          ADDR_SYSCTL: prdata_q[7:0] <= {6'h00, halted, cpu_mask_q};
          default: prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign PRDATA_O = prdata_q;
  assign PREADY_O = pready_q;
  assign PSLVERR_O = pslverr_q;
  assign COMPARE_OUTPUT_PIN_O = pin_q;
  assign COMPARE_OUTPUT_OE_O = oe_q;
  assign IRQ_O = irq_q;
  assign WAIT_WAKE_O = wake_q;

endmodule : timer16_pwm

`default_nettype wire

// ---- test/tmr_assertions.sv ----
// Checker for the register port and pin enable of the PWM timer.
// Assumes it is bound to timer16_pwm and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module tmr_checker
  import tmr_pkg::*;
(
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic COMPARE_OUTPUT_OE_O,
  input wire logic IRQ_O
);
  // ======
  // Access steps.
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);
  sequence s_wait;
    PSEL_I && PENABLE_I && !PREADY_O;
  endsequence
  sequence s_done;
    PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
  endsequence
  logic bad_adr;
  logic ctl_wr;
  // Only sixteen aligned words are mapped.
  assign bad_adr = (PADDR_I[1:0] != 2'b00) || (PADDR_I > ADDR_SYSCTL);
  assign ctl_wr = PREADY_O && PWRITE_I && (PADDR_I == ADDR_CTRL2 || PADDR_I == ADDR_CSR);
  // ======
  // Properties.
  AST_ONE_WAIT: assert property (s_wait |=> PREADY_O)
    else $error("access not answered after one wait state");
  AST_READY_PULSE: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready held longer than one cycle");
  AST_READY_CAUSE: assert property (PREADY_O |-> $past(PSEL_I && PENABLE_I))
    else $error("ready without an access phase");
  AST_RDATA_UPPER: assert property (PREADY_O && !PWRITE_I |-> PRDATA_O[31:8] == 24'h0)
    else $error("upper read data not zero");
  AST_SLVERR_MAP: assert property (PREADY_O && bad_adr |-> PSLVERR_O && PRDATA_O == 32'h0)
    else $error("unmapped access not refused");
  AST_SLVERR_GOOD: assert property (PREADY_O && !bad_adr |-> !PSLVERR_O)
    else $error("mapped access refused");
  AST_IRQ_MASK: assert property (s_done ##0 (PADDR_I == ADDR_SYSCTL && PWDATA_I[0])
    |-> ##[1:2] !IRQ_O)
    else $error("interrupt not masked");
  AST_OE_CAUSE: assert property ($changed(COMPARE_OUTPUT_OE_O)
    |-> $past(ctl_wr) || $past(ctl_wr, 2))
    else $error("pin enable moved without a control write");
endmodule : tmr_checker
bind timer16_pwm tmr_checker i_tmr_checker (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
  .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .COMPARE_OUTPUT_OE_O(COMPARE_OUTPUT_OE_O), .IRQ_O(IRQ_O));
`default_nettype wire

// ---- test/tmr_pins_model.sv ----
// Pin-side model: timer clock source, capture sources and the pad.
// Assumes one system clock; capture requests come one cycle wide.
`timescale 1ns/1ns
`default_nettype none
module tmr_pins_model (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic cap_req_i,
  input wire logic pin_i,
  input wire logic oe_i,
  output logic ext_clk_o,
  output logic cap_one_o,
  output logic cap_two_o,
  output logic pad_o
);
  logic [1:0] div_q;
  // ======
  // Pins.
  // The timer clock runs free at six system clocks a cycle. An undriven
  // pad shows the inverse of its last level, so a lost enable is seen.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_q <= 2'h0;
      ext_clk_o <= 1'b0;
      cap_two_o <= 1'b0;
      pad_o <= 1'b0;
    end else begin
      div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
      ext_clk_o <= ext_clk_o ^ (div_q == 2'h2);
      cap_two_o <= cap_req_i;
      pad_o <= oe_i ? pin_i : ~pad_o;
    end
  end
  // Pin one toggles all the time; a PWM timer must ignore it.
  assign cap_one_o = ext_clk_o;
endmodule : tmr_pins_model
`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking bench for the PWM timer through its register port.
// Assumes the pins model at the far side and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module testbench
  import tmr_pkg::*;
;
  logic clk, arst_n, psel, penable, pwrite, hwake, capreq, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r, c2;
  logic pready, pslverr, extc, cap1, cap2, pin, oe, irq, wwake, pad;
  int fail_count, n_tests, h, l, n;
  logic [7:0] ra[7] = '{ADDR_CTRL1, ADDR_CTRL2, ADDR_CMP1_HI, ADDR_CMP1_LO,
    ADDR_CMP2_HI, ADDR_CMP2_LO, ADDR_SYSCTL};
  logic [7:0] rv[7] = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h80, 8'h00, 8'h01};
  logic [1:0] cs[4] = '{CLK_DIV4, CLK_DIV8, CLK_EXT, CLK_DIV2};
  int dv[4] = '{4, 8, 6, 2};
  // ======
  // Clock and instances.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  timer16_pwm i_timer16_pwm (.CLK_I(clk), .ARST_N_I(arst_n), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .EXT_CLK_I(extc),
    .CAPTURE_PIN_ONE_I(cap1), .CAPTURE_PIN_TWO_I(cap2), .HALT_WAKE_I(hwake),
    .COMPARE_OUTPUT_PIN_O(pin), .COMPARE_OUTPUT_OE_O(oe), .IRQ_O(irq),
    .WAIT_WAKE_O(wwake));
  tmr_pins_model i_tmr_pins_model (.clk_i(clk), .arst_n_i(arst_n), .cap_req_i(capreq),
    .pin_i(pin), .oe_i(oe), .ext_clk_o(extc), .cap_one_o(cap1), .cap_two_o(cap2),
    .pad_o(pad));
  // ======
  // Tasks.
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One transfer; the request stands until ready is seen at an edge.
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    // No cycle count is assumed; only the watchdog ends a wait that never sees ready.
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wait_lv(input logic v);
    repeat (400) begin
      @(posedge clk);
      if (pad === v) break;
    end
  endtask : wait_lv
  // Counts high then low samples of one pad period from a rising edge.
  task meas(output int hi, output int lo);
    wait_lv(1'b0);
    wait_lv(1'b1);
    hi = 0;
    lo = 0;
    while (pad === 1'b1 && hi < 999) begin
      hi++;
      @(posedge clk);
    end
    while (pad === 1'b0 && lo < 999) begin
      lo++;
      @(posedge clk);
    end
  endtask : meas
  task cnt_hi(output int c);
    c = 0;
    repeat (60) begin
      @(posedge clk);
      c += (pad === 1'b1);
    end
  endtask : cnt_hi
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  // A hang counts as a mismatch.
  initial begin
    #200000;
    fail_count++;
    report_and_stop;
  end
  // ======
  // Sequence of tests.
  initial begin
    {arst_n, psel, penable, pwrite, hwake, capreq} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    fail_count = 0;
    n_tests = 0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    // The count is frozen first so that no match is missed while setting up.
    apb(1'b1, ADDR_CSR, 8'h04);
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 8'h0);
      chk("reset value", {24'h0, rv[i]}, r);
    end
    apb(1'b0, 8'h40, 8'h0);
    chk("unmapped error", 32'h1, {31'h0, e});
    apb(1'b1, 8'h05, 8'hff);
    chk("unaligned error", 32'h1, {31'h0, e});
    apb(1'b1, ADDR_CMP2_HI, 8'h00);
    apb(1'b1, ADDR_CMP2_LO, 8'h08);
    apb(1'b1, ADDR_CMP1_HI, 8'h00);
    apb(1'b1, ADDR_CMP1_LO, 8'h02);
    apb(1'b1, ADDR_CTRL1, 8'h81);
    apb(1'b1, ADDR_SYSCTL, 8'h00);
    apb(1'b1, ADDR_CSR, 8'h00);
    // Single pulse stays set beside PWM throughout.
    foreach (cs[i]) begin
      apb(1'b1, ADDR_CTRL2, 8'hb3 | {4'h0, cs[i], 2'b00});
      meas(h, l);
      meas(h, l);
      chk("high length", 6 * dv[i], h);
      chk("period length", 13 * dv[i], h + l);
    end
    apb(1'b1, ADDR_CMP1_HI, 8'h00);
    repeat (30) @(posedge clk);
    cnt_hi(n);
    chk("pin while inhibited", 0, n);
    apb(1'b1, ADDR_CMP1_LO, 8'h02);
    meas(h, l);
    meas(h, l);
    chk("high after low byte", 12, h);
    apb(1'b0, ADDR_CSR, 8'h0);
    chk("flags", 32'h80, r & 32'hd8);
    chk("irq", 32'h1, {31'h0, irq});
    chk("wait wake", 32'h1, {31'h0, wwake});
    apb(1'b1, ADDR_CTRL1, 8'h85);
    repeat (40) @(posedge clk);
    cnt_hi(n);
    chk("steady pin", 60, n);
    apb(1'b1, ADDR_SYSCTL, 8'h01);
    repeat (2) @(posedge clk);
    chk("masked irq", 32'h0, {31'h0, irq});
    chk("wake ignores mask", 32'h1, {31'h0, wwake});
    apb(1'b1, ADDR_SYSCTL, 8'h03);
    apb(1'b0, ADDR_CNT_LO, 8'h0);
    c2 = r;
    repeat (20) @(posedge clk);
    apb(1'b0, ADDR_CNT_LO, 8'h0);
    chk("held count", c2, r);
    chk("no wake in halt", 32'h0, {31'h0, wwake});
    capreq <= 1'b1;
    @(posedge clk);
    capreq <= 1'b0;
    repeat (3) @(posedge clk);
    hwake <= 1'b1;
    @(posedge clk);
    hwake <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1'b0, ADDR_CSR, 8'h0);
    chk("capture two flag", 32'h10, r & 32'h10);
    apb(1'b0, ADDR_CAP2_LO, 8'h0);
    chk("capture at exit", c2, r);
    apb(1'b0, ADDR_CNT_LO, 8'h0);
    chk("count resumed", 32'h1, {31'h0, r != c2});
    // A reset restarts the count from its reset value, not the running one.
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    apb(1'b0, ADDR_CNT_LO, 8'h0);
    chk("count after reset", {24'h0, CNT_RESET[7:0]}, r);
    report_and_stop;
  end
endmodule : testbench
`default_nettype wire
